/* File: cpu_side_model.sv */
// cpu side: bus status lines and free-running clock sources
// assumes commands change just after the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model
(
  // clock and commands
  input  wire logic mclk,
  input  wire logic do_shutdown,
  input  wire logic do_halt,
  // bus status and clock sources
  output logic      ads_n,
  output logic      w_r_n,
  output logic      m_io_n,
  output logic      d_c_n,
  output logic      addr_a1,
  output logic      double_rate_clock_in,
  output logic      oscillator_in_a,
  output logic      oscillator_in_b
);
  logic [3:0] cnt_q = 4'h0;
  wire        cyc = do_shutdown || do_halt;
  always @(negedge mclk)
    cnt_q <= cnt_q + 4'h1;
  assign double_rate_clock_in = cnt_q[0];
  assign oscillator_in_a      = cnt_q[1];
  assign oscillator_in_b      = cnt_q[2];
  assign ads_n   = !cyc;
  assign w_r_n   = cyc | cnt_q[2];
  assign m_io_n  = cyc | cnt_q[1];
  assign d_c_n   = !cyc & cnt_q[0];
  assign addr_a1 = cyc ? do_halt : cnt_q[3];
endmodule
`default_nettype wire

/* File: expansion_bus_clk_div.sv */
// expansion bus clock divider: mclk divided by 4, 6, 8 or 10
// assumes the select input is static or changes rarely
`timescale 1ns/1ps
`default_nettype none

module expansion_bus_clk_div
(
  // clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  rst_n,
  // divisor select
  input  wire logic [reset_clock_pkg::DIV_SEL_W-1:0] div_sel,
  // divided clock
  output logic                                       bus_clk_q
);

  logic [reset_clock_pkg::DIV_SEL_W-1:0]  sel_q;
  logic [reset_clock_pkg::HALF_CNT_W-1:0] half_cnt_q;
  logic [reset_clock_pkg::HALF_CNT_W-1:0] half_last;
  logic                                   half_end;
  logic                                   period_end;

  assign half_last = (sel_q == reset_clock_pkg::DIV_SEL_4)  ? reset_clock_pkg::HALF_LAST_4  :
                     (sel_q == reset_clock_pkg::DIV_SEL_6)  ? reset_clock_pkg::HALF_LAST_6  :
                     (sel_q == reset_clock_pkg::DIV_SEL_8)  ? reset_clock_pkg::HALF_LAST_8  :
                                                              reset_clock_pkg::HALF_LAST_10;
  assign half_end   = (half_cnt_q == half_last);
  // a period ends when the high half ends
  assign period_end = half_end && bus_clk_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sel_q      <= reset_clock_pkg::DIV_SEL_RESET;
      half_cnt_q <= reset_clock_pkg::HALF_ZERO;
      bus_clk_q  <= 1'b0;
    end
    else
    begin
      half_cnt_q <= half_end ? reset_clock_pkg::HALF_ZERO : half_cnt_q + reset_clock_pkg::HALF_ONE;
      if (half_end)
        bus_clk_q <= ~bus_clk_q;
      if (period_end)
        sel_q <= div_sel;
    end
  end

endmodule

`default_nettype wire

/* File: rcg_sva.sv */
// concurrent checks on the reset and clock generator ports
// assumes every input is synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module rcg_sva
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // watched ports
  input wire logic       power_good_in,
  input wire logic       kbd_warm_reset_req_n,
  input wire logic       ads_n,
  input wire logic       w_r_n,
  input wire logic       m_io_n,
  input wire logic       d_c_n,
  input wire logic       addr_a1,
  input wire logic       double_rate_clock_in,
  input wire logic       oscillator_in_a,
  input wire logic       oscillator_in_b,
  input wire logic [1:0] bus_clk_div_sel,
  input wire logic       cpu_reset_out,
  input wire logic       system_reset_n,
  input wire logic       processor_clock_out,
  input wire logic       expansion_bus_clock,
  input wire logic       oscillator_out_a,
  input wire logic       oscillator_out_b,
  input wire logic       shutdown_cycle_q
);
  logic [7:0] lq_q;
  logic [2:0] hc_q;
  logic [1:0] sq_q;
  logic [1:0] v_q;
  logic       ph_q;
  wire        spec = !ads_n && m_io_n && !d_c_n && w_r_n;
  wire        req = !power_good_in || !kbd_warm_reset_req_n || (spec && !addr_a1);
  wire  [2:0] ck_in = {double_rate_clock_in, oscillator_in_a, oscillator_in_b};
  wire  [2:0] ck_out = {processor_clock_out, oscillator_out_a, oscillator_out_b};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // cycles since last request, phase mirror, half length and the select in use
  always_ff @(posedge mclk)
  begin
    ph_q <= rst_n && !ph_q;
    lq_q <= (!rst_n || req) ? 8'h00 : lq_q + {7'h00, lq_q != 8'hff};
    hc_q <= (!rst_n || $changed(expansion_bus_clock)) ? 3'h0 : hc_q + 3'h1;
    sq_q <= !rst_n ? 2'h0 : $fell(expansion_bus_clock) ? $past(bus_clk_div_sel) : sq_q;
    v_q <= !rst_n ? 2'h0 : v_q + {1'b0, $changed(expansion_bus_clock) && v_q != 2'h3};
  end
  cold_hold_a: assert property (
    !power_good_in |=> cpu_reset_out && !system_reset_n)
    else $error("cold reset not held");
  warm_req_a: assert property (
    !kbd_warm_reset_req_n |=> cpu_reset_out)
    else $error("warm request ignored");
  warm_only_a: assert property (
    power_good_in && system_reset_n |=> system_reset_n)
    else $error("system reset without power fail");
  shut_pulse_a: assert property (
    spec && !addr_a1 |=> shutdown_cycle_q && cpu_reset_out)
    else $error("shutdown cycle missed");
  halt_skip_a: assert property (
    spec && addr_a1 |=> !shutdown_cycle_q)
    else $error("halt taken as shutdown");
  stretch_len_a: assert property (
    $fell(cpu_reset_out) |-> lq_q == 8'h50 || lq_q == 8'h51)
    else $error("reset stretch length wrong");
  release_phase_a: assert property (
    $fell(cpu_reset_out) |-> ph_q)
    else $error("reset released in wrong phase");
  sys_step_a: assert property (
    $rose(system_reset_n) |-> $fell(cpu_reset_out))
    else $error("system reset released apart");
  clk_copy_a: assert property (
    $past(rst_n) |-> ck_out == $past(ck_in))
    else $error("clock outputs do not follow");
  bus_half_a: assert property (
    $changed(expansion_bus_clock) && v_q == 2'h3 |-> hc_q == {1'b0, sq_q} + 3'h1)
    else $error("bus clock half period wrong");
endmodule
bind reset_and_clock_gen rcg_sva u_sva (.*);
`default_nettype wire

/* File: reset_and_clock_gen.sv */
// reset and shutdown sequencer with processor and expansion bus clock outputs
// assumes mclk is the double-rate clock; all inputs are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none

module reset_and_clock_gen
(
  // clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  rst_n,
  // reset sources
  input  wire logic                                  power_good_in,
  input  wire logic                                  kbd_warm_reset_req_n,
  // cpu bus status
  input  wire logic                                  ads_n,
  input  wire logic                                  w_r_n,
  input  wire logic                                  m_io_n,
  input  wire logic                                  d_c_n,
  input  wire logic                                  addr_a1,
  // clock inputs
  input  wire logic                                  double_rate_clock_in,
  input  wire logic                                  oscillator_in_a,
  input  wire logic                                  oscillator_in_b,
  // configuration
  input  wire logic [reset_clock_pkg::DIV_SEL_W-1:0] bus_clk_div_sel,
  // reset outputs
  output logic                                       cpu_reset_out,
  output logic                                       system_reset_n,
  // clock outputs
  output logic                                       processor_clock_out,
  output logic                                       expansion_bus_clock,
  output logic                                       oscillator_out_a,
  output logic                                       oscillator_out_b,
  // bus cycle class
  output logic                                       shutdown_cycle_q
);

  // ****************************************
  // bus cycle classification
  // ****************************************
  logic cyc_start;
  logic cyc_special;
  logic cyc_shutdown;

  assign cyc_start    = !ads_n;
  assign cyc_special  = m_io_n && !d_c_n && w_r_n;
  assign cyc_shutdown = cyc_start && cyc_special && !addr_a1;

  // ****************************************
  // reset sequencer
  // ****************************************
  reset_clock_pkg::seq_state_t          state_q;
  reset_clock_pkg::seq_state_t          state_d;
  logic [reset_clock_pkg::HOLD_CNT_W-1:0] hold_cnt_q;
  logic [reset_clock_pkg::HOLD_CNT_W-1:0] hold_cnt_d;
  logic                                 phase_q;
  logic                                 cold_req;
  logic                                 warm_req;
  logic                                 hold_done;
  logic                                 phase_ok;

  assign cold_req  = !power_good_in;
  assign warm_req  = !kbd_warm_reset_req_n || cyc_shutdown;
  assign hold_done = (hold_cnt_q == reset_clock_pkg::HOLD_LAST);
  assign phase_ok  = (phase_q == reset_clock_pkg::RELEASE_PHASE);

  always_comb
  begin
    state_d    = state_q;
    hold_cnt_d = hold_cnt_q;
    if (cold_req)
    begin
      state_d    = reset_clock_pkg::ST_COLD;
      hold_cnt_d = reset_clock_pkg::HOLD_ZERO;
    end
    else if (warm_req)
    begin
      // a warm request during cold reset keeps the cold reset going
      if (state_q != reset_clock_pkg::ST_COLD)
        state_d = reset_clock_pkg::ST_WARM;
      hold_cnt_d = reset_clock_pkg::HOLD_ZERO;
    end
    else
    begin
      unique case (state_q)
        reset_clock_pkg::ST_COLD,
        reset_clock_pkg::ST_WARM:
        begin
          if (!hold_done)
            hold_cnt_d = hold_cnt_q + reset_clock_pkg::HOLD_ONE;
          else if (phase_ok)
            state_d = reset_clock_pkg::ST_RUN;
        end
        reset_clock_pkg::ST_RUN:
        begin
          hold_cnt_d = reset_clock_pkg::HOLD_ZERO;
        end
        default:
        begin
          state_d    = reset_clock_pkg::ST_COLD;
          hold_cnt_d = reset_clock_pkg::HOLD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q    <= reset_clock_pkg::ST_COLD;
      hold_cnt_q <= reset_clock_pkg::HOLD_ZERO;
    end
    else
    begin
      state_q    <= state_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // ****************************************
  // cpu clock phase tracker
  // ****************************************
  // the cpu halves its double-rate clock internally; this bit follows
  // that halving so that every release lands in the same cpu phase
  logic phase_d;

  assign phase_d = !phase_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      phase_q <= reset_clock_pkg::RELEASE_PHASE;
    else
      phase_q <= phase_d;
  end

  // ****************************************
  // reset outputs
  // ****************************************
  // both levels come from the next state, so the pins move on the same
  // edge as the state register and never lag it by a cycle
  logic cpu_reset_d;
  logic system_reset_n_d;

  assign cpu_reset_d      = (state_d != reset_clock_pkg::ST_RUN);
  assign system_reset_n_d = (state_d != reset_clock_pkg::ST_COLD);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cpu_reset_out  <= 1'b1;
      system_reset_n <= 1'b0;
    end
    else
    begin
      cpu_reset_out  <= cpu_reset_d;
      system_reset_n <= system_reset_n_d;
    end
  end

  // ****************************************
  // shutdown cycle flag
  // ****************************************
  // one-cycle shutdown flag
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      shutdown_cycle_q <= 1'b0;
    else
      shutdown_cycle_q <= cyc_shutdown;
  end

  // ****************************************
  // clock outputs
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      processor_clock_out <= 1'b0;
      oscillator_out_a    <= 1'b0;
      oscillator_out_b    <= 1'b0;
    end
    else
    begin
      processor_clock_out <= double_rate_clock_in;
      oscillator_out_a    <= oscillator_in_a;
      oscillator_out_b    <= oscillator_in_b;
    end
  end

  expansion_bus_clk_div u_bus_div
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .div_sel   (bus_clk_div_sel),
    .bus_clk_q (expansion_bus_clock)
  );

endmodule

`default_nettype wire

/* File: reset_and_clock_gen_tb.sv */
// self-checking bench for the reset and clock generator
// assumes the cpu side model supplies status lines and clock sources
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_gen_tb;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       power_good_in = 1'b1;
  logic       kbd_warm_reset_req_n = 1'b1;
  logic       do_shutdown = 1'b0;
  logic       do_halt = 1'b0;
  logic [1:0] bus_clk_div_sel = 2'h0;
  wire        ads_n, w_r_n, m_io_n, d_c_n, addr_a1, double_rate_clock_in;
  wire        oscillator_in_a, oscillator_in_b, cpu_reset_out, system_reset_n;
  wire        processor_clock_out, expansion_bus_clock, oscillator_out_a;
  wire        oscillator_out_b, shutdown_cycle_q;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  always #5 mclk = ~mclk;
  cpu_side_model u_cpu (.*);
  reset_and_clock_gen u_dut (.*);
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // negedges until the level shows, which is the length of the other level
  task automatic wait_lvl(input logic lvl, output logic [7:0] n);
    n = 8'h00;
    while (expansion_bus_clock !== lvl && n < 8'h20)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic hold_len(output logic [7:0] n);
    n = 8'h00;
    while (cpu_reset_out === 1'b1 && n < 8'hc8)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic test_cold();
    logic [7:0] n;
    power_good_in = 1'b0;
    kbd_warm_reset_req_n = 1'b0;
    tick(5);
    chk("cpu reset", 8'h01, cpu_reset_out);
    chk("system reset", 8'h00, system_reset_n);
    power_good_in = 1'b1;
    kbd_warm_reset_req_n = 1'b1;
    hold_len(n);
    chk("cold length", 8'h01, n == 8'h50 || n == 8'h51);
    chk("system released", 8'h01, system_reset_n);
    $display("cold reset test done");
  endtask
  task automatic test_warm();
    logic [7:0] n;
    kbd_warm_reset_req_n = 1'b0;
    tick(1);
    kbd_warm_reset_req_n = 1'b1;
    chk("warm cpu reset", 8'h01, cpu_reset_out);
    tick(40);
    kbd_warm_reset_req_n = 1'b0;
    tick(1);
    kbd_warm_reset_req_n = 1'b1;
    hold_len(n);
    chk("warm length", 8'h01, n == 8'h50 || n == 8'h51);
    chk("system kept", 8'h01, system_reset_n);
    $display("warm reset test done");
  endtask
  task automatic test_shutdown();
    logic [7:0] n;
    do_shutdown = 1'b1;
    tick(1);
    do_shutdown = 1'b0;
    chk("shutdown pulse", 8'h01, shutdown_cycle_q);
    chk("shutdown reset", 8'h01, cpu_reset_out);
    tick(1);
    chk("pulse width", 8'h00, shutdown_cycle_q);
    hold_len(n);
    chk("shutdown length", 8'h01, n == 8'h4f || n == 8'h50);
    do_halt = 1'b1;
    tick(1);
    do_halt = 1'b0;
    chk("halt pulse", 8'h00, shutdown_cycle_q);
    chk("halt reset", 8'h00, cpu_reset_out);
    $display("shutdown test done");
  endtask
  task automatic test_bus_clock();
    logic [7:0] n;
    for (int s = 0; s < 4; s++)
    begin
      bus_clk_div_sel = 2'(s);
      tick(30);
      // start from a fresh rising edge, not from the middle of a high half
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, n);
      chk("high half", 8'(s + 2), n);
      wait_lvl(1'b1, n);
      chk("low half", 8'(s + 2), n);
    end
    $display("bus clock test done");
  endtask
  task automatic test_follow();
    logic [2:0] prev;
    logic [2:0] seen;
    #1;
    repeat (8)
    begin
      prev = {double_rate_clock_in, oscillator_in_a, oscillator_in_b};
      tick(1);
      #1;
      seen = {processor_clock_out, oscillator_out_a, oscillator_out_b};
      chk("clock copy", {5'h00, prev}, {5'h00, seen});
    end
    $display("clock follow test done");
  endtask
  initial
  begin
    tick(2);
    rst_n = 1'b1;
    tick(100);
    test_cold();
    test_warm();
    test_shutdown();
    test_bus_clock();
    test_follow();
    summarize();
  end
endmodule
`default_nettype wire

/* File: reset_clock_pkg.sv */
// constants shared by the reset sequencer and the expansion bus clock divider
// assumes mclk is the double-rate clock that the cpu also receives
package reset_clock_pkg;

  // least reset stretch, counted in mclk (double-rate clock) cycles
  localparam int unsigned RESET_HOLD_CYCLES = 80;
  localparam int unsigned HOLD_CNT_W        = 7;
  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST =
    HOLD_CNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_ZERO = 7'h00;
  localparam logic [HOLD_CNT_W-1:0] HOLD_ONE  = 7'h01;

  // cpu internal phase in which resets may be released
  localparam logic RELEASE_PHASE = 1'b0;

  // expansion bus clock divisor select codes
  localparam int unsigned DIV_SEL_W = 2;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_4  = 2'h0;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_6  = 2'h1;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_8  = 2'h2;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_10 = 2'h3;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = DIV_SEL_4;

  // half period of the expansion bus clock, in mclk cycles, minus one
  localparam int unsigned HALF_CNT_W = 3;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST_4  = 3'h1;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST_6  = 3'h2;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST_8  = 3'h3;
  localparam logic [HALF_CNT_W-1:0] HALF_LAST_10 = 3'h4;
  localparam logic [HALF_CNT_W-1:0] HALF_ZERO    = 3'h0;
  localparam logic [HALF_CNT_W-1:0] HALF_ONE     = 3'h1;

  // sequencer states
  typedef enum logic [2:0] {
    ST_COLD = 3'b001,
    ST_WARM = 3'b010,
    ST_RUN  = 3'b100
  } seq_state_t;

endpackage
